//--- inc/sdd_pkg.sv
// Constants shared by the supply drop detector modules
`default_nettype none
package sdd_pkg;
    // System clock rate
    localparam int unsigned CLK_HZ = 200_000_000;
    // Nominal oscillator rate and the clock cycles per oscillator tick
    localparam int unsigned OSC_HZ = 32_768;
    localparam int unsigned OSC_DIV_DFLT = CLK_HZ / OSC_HZ;
    localparam int unsigned DIV_W = 13;
    // Sampling window length in microseconds, and in oscillator ticks, rounded up
    localparam int unsigned WIN_US = 15_600;
    localparam int unsigned WIN_TICKS = (WIN_US * OSC_HZ + 999_999) / 1_000_000;
    // Oscillator ticks in one second
    localparam int unsigned SEC_TICKS = OSC_HZ;
    localparam int unsigned SEC_W = 15;
    // Bit of the second counter that toggles at 1 Hz
    localparam int unsigned HZ_BIT = SEC_W - 1;
    // Reset values
    localparam logic RST_LATCH = 1'b0;
    localparam logic RST_SUSP = 1'b0;
    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_POR = 1'b1;
    localparam logic RST_INT_N = 1'b1;
endpackage : sdd_pkg
`default_nettype wire

//--- inc/sdd_tb_if.sv
// Timebase signals passed from the oscillator divider to the detector logic
`timescale 1ns/10ps
`default_nettype none
interface sdd_tb_if;
    logic win;
    logic win_end;
    logic hz;
    modport src (output win, output win_end, output hz);
    modport snk (input win, input win_end, input hz);
endinterface : sdd_tb_if
`default_nettype wire

//--- hdl/sdd_timebase.sv
// Oscillator divider chain producing the tick, sampling window and 1 Hz signal
`timescale 1ns/10ps
`default_nettype none
module sdd_timebase #(
    parameter logic [sdd_pkg::DIV_W-1:0] OSC_DIV = sdd_pkg::DIV_W'(sdd_pkg::OSC_DIV_DFLT)
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    sdd_tb_if.src tb
);
    import sdd_pkg::*;

    logic [DIV_W-1:0] div_cnt;
    logic [SEC_W-1:0] sec_cnt;
    logic tick;
    logic win;
    logic win_end;
    wire div_last = (div_cnt == OSC_DIV - DIV_W'(1));
    wire sec_last = (sec_cnt == SEC_W'(SEC_TICKS - 1));
    wire win_last = (sec_cnt == SEC_W'(WIN_TICKS - 1));
    wire [DIV_W-1:0] next_div_cnt = div_last ? '0 : div_cnt + DIV_W'(1);
    wire [SEC_W-1:0] next_sec_cnt = sec_last ? '0 : sec_cnt + SEC_W'(1);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_cnt <= '0;
            sec_cnt <= '0;
            tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            tick <= div_last;
            if (tick) begin
                sec_cnt <= next_sec_cnt; // see [R11]
            end
        end
    end

    // Window covers the first ticks of every second
    always_comb begin
        win = (sec_cnt < SEC_W'(WIN_TICKS)); // see [R1]
        win_end = tick && win_last;
    end

    assign tb.win = win;
    assign tb.win_end = win_end;
    assign tb.hz = sec_cnt[HZ_BIT]; // see [R7]

    a_win_end_pos: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [R11]
        win_end |=> !win && sec_cnt == SEC_W'(WIN_TICKS))
        else $error("window did not close after its last tick");

    a_tick_spacing: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [R11]
        tick |=> !tick)
        else $error("oscillator ticks back to back");
endmodule // sdd_timebase
`default_nettype wire

//--- hdl/sdd_top.sv
// Supply drop detector: periodic sampling, drop latch, status flag and 1 Hz power-on output
//
// Notes on behaviour
// [R1] Comparator enabled 15.6 ms once each second
// [R2] Drop sets latch and suspends sampling
// [R3] Status read copies latch, resumes sampling
// [R4] Latch held until initialization or status read
// [R5] Latched state shown as supply drop flag
// [R6] First read 1, later good window clears
// [R7] Power-on drives 1 Hz on interrupt output
// [R8] Host may skip reset on backup power
// [R9] Host should check test flag on noise
// [R10] Host talks only after power is stable
// [R11] Window derived from 32768 Hz divider chain
`timescale 1ns/10ps
`default_nettype none
module sdd_top #(
    parameter logic [sdd_pkg::DIV_W-1:0] OSC_DIV = sdd_pkg::DIV_W'(sdd_pkg::OSC_DIV_DFLT)
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    // Comparator result: supply below drop_threshold
    input wire logic cmp_low_i,
    // Decoded serial commands, one-cycle pulses
    input wire logic init_i,
    input wire logic stat_rd_i,
    input wire logic cmd_i,
    output logic cmp_en_o,
    output logic supply_drop_flag_o,
    output logic int_n_o
);
    import sdd_pkg::*;

    sdd_tb_if tb ();

    sdd_timebase #(
        .OSC_DIV(OSC_DIV)
    ) u_timebase (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .tb(tb)
    );

    logic supply_drop_latch;
    logic susp;
    logic por;
    logic cmp_en;
    logic flag;
    logic int_n;

    // A sample counts only while sampling is armed
    wire drop_now = cmp_en && cmp_low_i && !susp; // see [R2]

    // Initialization wins; a drop in the same cycle as a read keeps sampling stopped
    wire next_susp = init_i ? 1'b0 :
                     drop_now ? 1'b1 : // see [R2]
                     stat_rd_i ? 1'b0 : // see [R3]
                     susp; // see [R4]

    // A completed good window clears the latch once sampling is armed again
    wire good_end = tb.win_end && !susp && !drop_now; // see [R6]

    wire next_latch = init_i ? 1'b0 :
                      drop_now ? 1'b1 : // see [R2]
                      good_end ? 1'b0 : // see [R6]
                      supply_drop_latch; // see [R4]

    // Comparator stays idle outside the window and while suspended
    wire next_cmp_en = tb.win && !tb.win_end && !next_susp; // see [R1]

    // Status read shifts out the latch as it stood before this cycle
    wire next_flag = init_i ? 1'b0 :
                     stat_rd_i ? supply_drop_latch : // see [R3]
                     flag; // see [R5]

    wire next_por = por && !init_i;

    // Active low 1 Hz square wave while the power-on state lasts
    wire next_int_n = next_por ? !tb.hz : 1'b1; // see [R7]

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            supply_drop_latch <= RST_LATCH;
            susp <= RST_SUSP;
            flag <= RST_FLAG;
            por <= RST_POR;
        end else begin
            supply_drop_latch <= next_latch;
            susp <= next_susp;
            flag <= next_flag;
            por <= next_por;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmp_en <= 1'b0;
            int_n <= RST_INT_N;
        end else begin
            cmp_en <= next_cmp_en;
            int_n <= next_int_n;
        end
    end

    assign cmp_en_o = cmp_en;
    assign supply_drop_flag_o = flag;
    assign int_n_o = int_n;

    // Helper: clock cycles the comparator has been enabled in a row
    logic [31:0] en_run;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            en_run <= '0;
        end else begin
            en_run <= cmp_en ? en_run + 32'h1 : '0;
        end
    end

    a_en_in_window: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [R1]
        cmp_en_o |-> $past(tb.win) && !susp)
        else $error("comparator enabled outside the sampling window");

    a_en_run_bound: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [R1]
        en_run <= 32'(WIN_TICKS) * 32'(OSC_DIV))
        else $error("comparator enabled longer than one window");

    a_drop_latches: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [R2]
        cmp_en_o && cmp_low_i && !init_i |=> supply_drop_latch && susp && !cmp_en_o)
        else $error("drop did not set latch and stop sampling");

    a_susp_no_sample: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [R4]
        susp && !stat_rd_i && !init_i |=> !cmp_en_o && susp)
        else $error("sampling while suspended");

    a_read_copies: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [R3]
        stat_rd_i && !init_i && !drop_now
        |=> supply_drop_flag_o == $past(supply_drop_latch) && !susp)
        else $error("status read did not copy latch and resume");

    a_other_cmd_keeps: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [R3]
        susp && cmd_i && !stat_rd_i && !init_i |=> susp)
        else $error("other command resumed sampling");

    a_latch_held: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [R4]
        supply_drop_latch && susp && !init_i |=> supply_drop_latch)
        else $error("latch lost while suspended");

    a_flag_stable: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [R5]
        !stat_rd_i && !init_i |=> $stable(supply_drop_flag_o))
        else $error("flag changed without a status read");

    a_good_clears: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [R6]
        tb.win_end && !susp && !drop_now && !init_i |=> !supply_drop_latch)
        else $error("good window did not clear the latch");

    a_por_hz_out: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [R7]
        por && !init_i |=> int_n_o == !$past(tb.hz))
        else $error("power-on 1 Hz output wrong");

    a_int_idle: assert property (@(posedge clk_i) disable iff (!rstn_i) // see [R7]
        !por |=> int_n_o)
        else $error("interrupt output active after power-on state ended");
endmodule // sdd_top
`default_nettype wire

//--- verif/sdd_supply_model.sv
// Comparator stand-in that reports the supply level only while it is enabled
`timescale 1ns/10ps
`default_nettype none
module sdd_supply_model (
    input wire logic clk_i,
    input wire logic supply_low_i,
    input wire logic cmp_en_i,
    output logic cmp_low_o
);
    logic junk = 1'b0;
    // A disabled comparator gives no valid result, so its output wanders
    always @(posedge clk_i) junk <= ~junk;
    assign cmp_low_o = cmp_en_i ? supply_low_i : junk;
endmodule // sdd_supply_model
`default_nettype wire

//--- verif/sdd_top_test.sv
// Self-checking bench for the supply drop detector
`timescale 1ns/10ps
`default_nettype none
module sdd_top_test;
    import sdd_pkg::*;
    localparam int DIV = 2;
    localparam int SEC = int'(SEC_TICKS) * DIV;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic supply_low = 1'b0;
    logic init_i = 1'b0;
    logic stat_rd_i = 1'b0;
    logic cmd_i = 1'b0;
    logic cmp_low, cmp_en, flag, int_n;
    int err_total = 0;
    int n_tests = 0;
    int t = 0;
    logic [15:0] rnd = 16'h3a1d;
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (rstn_i) t <= t + 1;
    sdd_top #(.OSC_DIV(DIV_W'(DIV))) dut (.clk_i(clk_i), .rstn_i(rstn_i),
        .cmp_low_i(cmp_low), .init_i(init_i), .stat_rd_i(stat_rd_i), .cmd_i(cmd_i),
        .cmp_en_o(cmp_en), .supply_drop_flag_o(flag), .int_n_o(int_n));
    sdd_supply_model model (.clk_i(clk_i), .supply_low_i(supply_low),
        .cmp_en_i(cmp_en), .cmp_low_o(cmp_low));
    function automatic logic exp_en(int c);
        return (c % SEC) < int'(WIN_TICKS) * DIV;
    endfunction
    function automatic logic exp_int_n(int c);
        return ((c / (SEC / 2)) % 2) == 0;
    endfunction
    function automatic logic [15:0] lfsr(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic check(string name, logic seen, logic exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
        end
    endtask
    // Bounded wait; running out of edges counts as a mismatch
    task automatic go_to(int c);
        for (int i = 0; i < 2 * SEC && t < c; i++) @(negedge clk_i);
        if (t < c) err_total++;
    endtask
    // One-cycle command: 0 initialization, 1 status read, 2 other command
    task automatic pulse(int sel);
        init_i = (sel == 0);
        stat_rd_i = (sel == 1);
        cmd_i = (sel == 2);
        @(negedge clk_i);
        init_i = 1'b0;
        stat_rd_i = 1'b0;
        cmd_i = 1'b0;
    endtask
    task automatic complete_run;
        if (err_total == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge clk_i);
        err_total++;
        complete_run;
    end
    initial begin
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        check("cmp_en", cmp_en, 1'b0);
        check("int_n", int_n, 1'b1);
        // Commands start only once power is stable
        rstn_i = 1'b1;
        go_to(1);
        check("cmp_en", cmp_en, 1'b1);
        go_to(20);
        check("cmp_en", cmp_en, exp_en(t));
        check("int_n", int_n, exp_int_n(t));
        check("flag", flag, 1'b0);
        rnd = lfsr(rnd);
        go_to(30 + int'(rnd[5:0]));
        supply_low = 1'b1;
        @(negedge clk_i);
        check("cmp_en", cmp_en, 1'b0);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            supply_low = rnd[1];
            cmd_i = rnd[0];
            @(negedge clk_i);
        end
        supply_low = 1'b0;
        cmd_i = 1'b0;
        @(negedge clk_i);
        check("cmp_en", cmp_en, 1'b0);
        check("flag", flag, 1'b0);
        // Host carries on without a reset command first
        pulse(1);
        check("flag", flag, 1'b1);
        @(negedge clk_i);
        check("cmp_en", cmp_en, 1'b1);
        go_to(int'(WIN_TICKS) * DIV + 50);
        check("cmp_en", cmp_en, exp_en(t));
        pulse(1);
        check("flag", flag, 1'b0);
        go_to(SEC / 2 + 500);
        check("int_n", int_n, exp_int_n(t));
        pulse(0);
        go_to(SEC - 500);
        check("int_n", int_n, 1'b1);
        check("cmp_en", cmp_en, exp_en(t));
        go_to(SEC + 100);
        check("cmp_en", cmp_en, exp_en(t));
        supply_low = 1'b1;
        stat_rd_i = 1'b1;
        @(negedge clk_i);
        supply_low = 1'b0;
        stat_rd_i = 1'b0;
        check("flag", flag, 1'b0);
        check("cmp_en", cmp_en, 1'b0);
        repeat (3) @(negedge clk_i);
        check("cmp_en", cmp_en, 1'b0);
        pulse(0);
        check("flag", flag, 1'b0);
        @(negedge clk_i);
        check("cmp_en", cmp_en, 1'b1);
        // Status word read back after initialization
        pulse(1);
        check("flag", flag, 1'b0);
        complete_run;
    end
endmodule // sdd_top_test
`default_nettype wire
